// file: rtl/pwig_pkg.sv
// Purpose: Constants for the per-port wake and interrupt gating block.
// Assumes: 16-bit register address, upper nibble is the port number.
// Notes:   Offsets are the low twelve address bits inside a port page.
package pwig_pkg;

  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 8;
  localparam int PORT_W     = 4;
  localparam int OFS_W      = 12;
  localparam int STATION_W  = 48;
  localparam int EVT_W      = 3;
  localparam int INT_W      = 2;

  // Register offsets within a port page.
  localparam logic [OFS_W-1:0] OFS_WAKE_EVENT  = 12'h013;
  localparam logic [OFS_W-1:0] OFS_WAKE_ENABLE = 12'h017;
  localparam logic [OFS_W-1:0] OFS_INT_STATUS  = 12'h01B;
  localparam logic [OFS_W-1:0] OFS_INT_MASK    = 12'h01F;
  localparam logic [OFS_W-1:0] OFS_WIRQ_STATUS = 12'h00C;
  localparam logic [OFS_W-1:0] OFS_WIRQ_MASK   = 12'h00D;

  // Wake event and enable bit positions.
  localparam int BIT_ENERGY  = 0;
  localparam int BIT_LINK    = 1;
  localparam int BIT_PATTERN = 2;

  // Port interrupt status and mask bit positions.
  localparam int BIT_FILTER_INT = 0;
  localparam int BIT_PHY_INT    = 1;

  // Bits that exist on each kind of port.
  localparam logic [EVT_W-1:0] EVT_PHY_PORT = 3'h7;
  localparam logic [EVT_W-1:0] EVT_MAC_PORT = 3'h4;
  localparam logic [INT_W-1:0] INT_PHY_PORT = 2'h3;
  localparam logic [INT_W-1:0] INT_MAC_PORT = 2'h1;

  // Reset values.
  localparam logic [EVT_W-1:0]  WAKE_EN_RST   = 3'h0;
  localparam logic [EVT_W-1:0]  WAKE_EVT_RST  = 3'h0;
  localparam logic [EVT_W-1:0]  WIRQ_STAT_RST = 3'h0;
  localparam logic [EVT_W-1:0]  WIRQ_MASK_RST = 3'h0;
  localparam logic [INT_W-1:0]  INT_MASK_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RST   = 8'h00;

  localparam logic [PORT_W-1:0] PORT_NUM_DEF  = 4'h1;

endpackage : pwig_pkg

// file: rtl/pwig_port_wake_irq.sv
// Purpose: Wake event enables, wake flags and port interrupt status/mask
//          for one switch port, with a plain register port.
// Assumes: Event inputs are one-cycle pulses synchronous to core_clk_i.
// Notes:   Set wins over every clear in the same cycle.
//          The port number and transceiver presence are parameters, so
//          one copy of this module serves each of the three ports.
//          Reserved bits read as zero and ignore writes.
// Contract
// - Enable bit 2 alone lets a matching pattern frame raise wake output.
// - A pattern frame counts only if addressed to the station address.
// - Enable bit 1 alone lets link-up raise the wake output.
// - Enable bit 0 alone lets cable energy raise the wake output.
// - Link-up and energy enables work only on transceiver ports, not MAC.
// - Status bit 1 follows the transceiver interrupt, on transceiver ports.
// - Status bit 1 only summarises transceiver causes held elsewhere.
// - Status bit 0 is set by a filter counter interrupt, not read-cleared.
// - Every port, the MAC port too, has the filter status and mask bit.
// - Toggling mask bit 0 clears the access filter status bit.
// - Port mask bits are active low and reset to zero.
// - A status bit reaches the interrupt only while its mask bit enables it.
// - Wake enables reset to zero and reserved bits read as zero.
// - Link-up and energy wake flags are set on detection and cleared by a write.
// - Event bit 0 is the cable energy flag, set on energy and cleared by a write.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module pwig_port_wake_irq #(
  parameter logic [pwig_pkg::PORT_W-1:0] PORT_NUM = pwig_pkg::PORT_NUM_DEF,
  parameter bit                          HAS_PHY  = 1'b1
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_i,
  input  wire logic [pwig_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [pwig_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                           wr_en_i,
  input  wire logic                           rd_en_i,
  output logic      [pwig_pkg::DATA_W-1:0]    rd_data_o,
  input  wire logic [pwig_pkg::STATION_W-1:0] station_addr_i,
  input  wire logic                           pattern_det_i,
  input  wire logic [pwig_pkg::STATION_W-1:0] pattern_dst_i,
  input  wire logic                           link_up_i,
  input  wire logic                           energy_i,
  input  wire logic                           phy_irq_i,
  input  wire logic                           filter_irq_i,
  output logic                                wake_event_out_o,
  output logic                                port_irq_o,
  output logic                                wake_irq_o
);

  localparam int EW = pwig_pkg::EVT_W;
  localparam int IW = pwig_pkg::INT_W;
  localparam int DW = pwig_pkg::DATA_W;

  logic [EW-1:0] wake_en_r;
  logic [EW-1:0] wake_evt_r;
  logic [EW-1:0] wirq_stat_r;
  logic [EW-1:0] wirq_mask_r;
  logic [IW-1:0] int_mask_r;
  logic          filter_stat_r;
  logic [DW-1:0] rd_data_r;
  logic          wake_out_r;
  logic          port_irq_r;
  logic          wake_irq_r;

  // Address decode. The upper nibble picks the port page and the low
  // twelve bits the register; a write to another page or an unmapped
  // offset is ignored and such a read returns zero.
  wire                      port_sel;
  wire [pwig_pkg::OFS_W-1:0] ofs;
  wire                      hit_evt;
  wire                      hit_en;
  wire                      hit_stat;
  wire                      hit_mask;
  wire                      hit_wstat;
  wire                      hit_wmask;

  assign port_sel  = addr_i[pwig_pkg::ADDR_W-1 -: pwig_pkg::PORT_W]
                     == PORT_NUM;
  assign ofs       = addr_i[pwig_pkg::OFS_W-1:0];
  assign hit_evt   = port_sel && (ofs == pwig_pkg::OFS_WAKE_EVENT);
  assign hit_en    = port_sel && (ofs == pwig_pkg::OFS_WAKE_ENABLE);
  assign hit_stat  = port_sel && (ofs == pwig_pkg::OFS_INT_STATUS);
  assign hit_mask  = port_sel && (ofs == pwig_pkg::OFS_INT_MASK);
  assign hit_wstat = port_sel && (ofs == pwig_pkg::OFS_WIRQ_STATUS);
  assign hit_wmask = port_sel && (ofs == pwig_pkg::OFS_WIRQ_MASK);

  // Bits that exist on this kind of port. A MAC port has no transceiver,
  // so its link, energy and transceiver interrupt bits are tied off
  // here and every later stage but the wake interrupt mask sees them as absent.
  wire [EW-1:0] evt_exist;
  wire [IW-1:0] int_exist;

  assign evt_exist = HAS_PHY ? pwig_pkg::EVT_PHY_PORT
                             : pwig_pkg::EVT_MAC_PORT;
  assign int_exist = HAS_PHY ? pwig_pkg::INT_PHY_PORT
                             : pwig_pkg::INT_MAC_PORT;

  // Detection pulses, gated to the sources this port has.
  // A pattern frame whose destination is not the station address is
  // dropped here, before it can set any flag.
  wire          dst_match;
  wire          pattern_match;
  wire [EW-1:0] evt_raw;
  wire [EW-1:0] evt_in;

  assign dst_match     = pattern_dst_i == station_addr_i;
  assign pattern_match = pattern_det_i && dst_match;
  assign evt_raw[pwig_pkg::BIT_PATTERN] = pattern_match;
  assign evt_raw[pwig_pkg::BIT_LINK]    = link_up_i;
  assign evt_raw[pwig_pkg::BIT_ENERGY]  = energy_i;
  assign evt_in = evt_raw & evt_exist;

  // Write and read-clear strobes. The bus never raises both strobes in
  // one cycle, so a read-clear and a write cannot collide on one
  // register.
  wire wr_evt;
  wire wr_en_reg;
  wire wr_mask;
  wire wr_wmask;
  wire rd_wstat;

  assign wr_evt    = wr_en_i && hit_evt;
  assign wr_en_reg = wr_en_i && hit_en;
  assign wr_mask   = wr_en_i && hit_mask;
  assign wr_wmask  = wr_en_i && hit_wmask;
  assign rd_wstat  = rd_en_i && hit_wstat;

  // Per-bit flag update: a detection in the clear cycle keeps the flag.
  // Losing such an event would hide a wake request from software, while
  // keeping it costs only one extra clear.
  wire [EW-1:0] wake_evt_nxt;
  wire [EW-1:0] wirq_stat_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < EW; gi++) begin : g_evt
      assign wake_evt_nxt[gi]  = evt_in[gi]
                                 | (wake_evt_r[gi]
                                    & ~(wr_evt & wr_data_i[gi]));
      assign wirq_stat_nxt[gi] = evt_in[gi]
                                 | (wirq_stat_r[gi] & ~rd_wstat);
    end
  endgenerate

  wire [EW-1:0] wake_en_nxt;
  wire [EW-1:0] wirq_mask_nxt;

  assign wake_en_nxt   = wr_en_reg ? (wr_data_i[EW-1:0] & evt_exist)
                                   : wake_en_r;
  assign wirq_mask_nxt = wr_wmask ? wr_data_i[EW-1:0] : wirq_mask_r;

  // Port interrupt status and mask.
  // The filter status is cleared by a change of its mask bit, so the old
  // and the new mask bit are compared on every mask write.
  wire [IW-1:0] int_mask_nxt;
  wire          filter_mask_old;
  wire          filter_mask_new;
  wire          filter_toggle;
  wire          filter_stat_nxt;
  wire [IW-1:0] int_stat_now;
  wire [IW-1:0] int_stat_nxt;

  assign int_mask_nxt    = wr_mask ? (wr_data_i[IW-1:0] & int_exist)
                                   : int_mask_r;
  assign filter_mask_old = int_mask_r[pwig_pkg::BIT_FILTER_INT];
  assign filter_mask_new = wr_data_i[pwig_pkg::BIT_FILTER_INT];
  assign filter_toggle   = wr_mask
                           && (filter_mask_new != filter_mask_old);
  assign filter_stat_nxt = filter_irq_i
                           | (filter_stat_r & ~filter_toggle);
  assign int_stat_now[pwig_pkg::BIT_FILTER_INT] = filter_stat_r;
  assign int_stat_now[pwig_pkg::BIT_PHY_INT]    = phy_irq_i
                                                  & HAS_PHY;
  assign int_stat_nxt[pwig_pkg::BIT_FILTER_INT] = filter_stat_nxt;
  assign int_stat_nxt[pwig_pkg::BIT_PHY_INT]    = phy_irq_i & HAS_PHY;

  // Output terms, registered so that each output is a flip-flop.
  // They are formed from next-state values, so an output moves on the
  // same edge as the flag that drives it and never lags it by a cycle.
  wire          wake_out_nxt;
  wire          port_irq_nxt;
  wire          wake_irq_nxt;
  wire [EW-1:0] wake_armed;
  wire [IW-1:0] int_unmasked;
  wire [EW-1:0] wirq_armed;

  assign wake_armed   = wake_evt_nxt & wake_en_nxt;
  assign int_unmasked = int_stat_nxt & ~int_mask_nxt;
  assign wirq_armed   = wirq_stat_nxt & wirq_mask_nxt;

  // A low port mask bit lets its source through, so that mask is
  // inverted above while the wake interrupt mask is used as it stands.
  assign wake_out_nxt = |wake_armed;
  assign port_irq_nxt = |int_unmasked;
  assign wake_irq_nxt = |wirq_armed;

  // Read words, one per register, reserved bits padded with zeros.
  // Bits a MAC port lacks are already zero in the stored values, except in the wake interrupt mask.
  wire [DW-1:0] rd_word_evt;
  wire [DW-1:0] rd_word_en;
  wire [DW-1:0] rd_word_stat;
  wire [DW-1:0] rd_word_mask;
  wire [DW-1:0] rd_word_wstat;
  wire [DW-1:0] rd_word_wmask;

  assign rd_word_evt   = {{(DW-EW){1'b0}}, wake_evt_r};
  assign rd_word_en    = {{(DW-EW){1'b0}}, wake_en_r};
  assign rd_word_stat  = {{(DW-IW){1'b0}}, int_stat_now};
  assign rd_word_mask  = {{(DW-IW){1'b0}}, int_mask_r};
  assign rd_word_wstat = {{(DW-EW){1'b0}}, wirq_stat_r};
  assign rd_word_wmask = {{(DW-EW){1'b0}}, wirq_mask_r};

  // Read data mux; idle and unmapped reads return zero so that the
  // data lines never carry a stale value between reads.
  wire [DW-1:0] rd_data_nxt;

  assign rd_data_nxt = !rd_en_i  ? pwig_pkg::RD_DATA_RST :
                       hit_evt   ? rd_word_evt :
                       hit_en    ? rd_word_en :
                       hit_stat  ? rd_word_stat :
                       hit_mask  ? rd_word_mask :
                       hit_wstat ? rd_word_wstat :
                       hit_wmask ? rd_word_wmask :
                                   pwig_pkg::RD_DATA_RST;

  // State registers. Each has a block of its own so that its reset
  // value and its update stand side by side; all share the one clock
  // and the synchronous reset.

  // Wake enables. Only the bits that exist on this port can be set, so
  // a MAC port reads its link and energy enables back as zero.
  // Writes to the reserved bits are dropped.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_en_r <= pwig_pkg::WAKE_EN_RST;
    end else begin
      wake_en_r <= wake_en_nxt;
    end
  end

  // Wake flags. They are set whatever the enables say, so enabling a
  // source later with its flag still pending raises the wake output.
  // Software clears a flag by writing a one to it.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_evt_r <= pwig_pkg::WAKE_EVT_RST;
    end else begin
      wake_evt_r <= wake_evt_nxt;
    end
  end

  // Wake interrupt status. Reading the register clears it, but an event
  // in the same cycle as that read survives.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wirq_stat_r <= pwig_pkg::WIRQ_STAT_RST;
    end else begin
      wirq_stat_r <= wirq_stat_nxt;
    end
  end

  // Wake interrupt mask; a one lets the matching status bit through.
  // Unlike the port mask, this mask is active high.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wirq_mask_r <= pwig_pkg::WIRQ_MASK_RST;
    end else begin
      wirq_mask_r <= wirq_mask_nxt;
    end
  end

  // Port interrupt mask, active low. A MAC port has no transceiver bit,
  // so that bit is held at zero there.
  // Writes to the reserved bits are dropped.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      int_mask_r <= pwig_pkg::INT_MASK_RST;
    end else begin
      int_mask_r <= int_mask_nxt;
    end
  end

  // Access filter status. Reads leave it alone; only a change of mask
  // bit 0 clears it, and a filter event in that same cycle wins.
  // The transceiver bit is not stored: it follows its input live.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      filter_stat_r <= 1'b0;
    end else begin
      filter_stat_r <= filter_stat_nxt;
    end
  end

  // Read data register. It holds a value for exactly one cycle after a
  // read strobe and is zero otherwise.
  // A read and a clear in one cycle show the value before the clear.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_r <= pwig_pkg::RD_DATA_RST;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Wake event output register.
  // It is driven straight to the pin with no logic after it.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_out_r <= 1'b0;
    end else begin
      wake_out_r <= wake_out_nxt;
    end
  end

  // Port interrupt request toward the global interrupt logic.
  // It stays high while any unmasked status bit is set.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port_irq_r <= 1'b0;
    end else begin
      port_irq_r <= port_irq_nxt;
    end
  end

  // Wake interrupt output.
  // It stays high while any enabled wake interrupt status bit is set.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_irq_r <= 1'b0;
    end else begin
      wake_irq_r <= wake_irq_nxt;
    end
  end

  // The outputs come straight from their flip-flops, so no glitch from
  // the decode logic can reach the pins.
  assign rd_data_o        = rd_data_r;
  assign wake_event_out_o = wake_out_r;
  assign port_irq_o       = port_irq_r;
  assign wake_irq_o       = wake_irq_r;

endmodule : pwig_port_wake_irq

// file: dv/pwig_evt_src.sv
// Purpose: Event detector model feeding one port of the block.
// Assumes: fire_i bits are filter, pattern, link, energy; one cycle each.
// Notes:   The pattern destination changes every cycle outside a detection.
`timescale 1ns/10ps
module pwig_evt_src (
  input  wire logic        core_clk_i,
  input  wire logic [3:0]  fire_i,
  input  wire logic        bad_dst_i,
  input  wire logic [47:0] station_i,
  output logic             energy_o = 1'b0,
  output logic             link_up_o = 1'b0,
  output logic             pattern_det_o = 1'b0,
  output logic             filter_irq_o = 1'b0,
  output logic [47:0]      pattern_dst_o = 48'h0
);
  always @(posedge core_clk_i) begin
    {filter_irq_o, pattern_det_o, link_up_o, energy_o} <= fire_i;
    pattern_dst_o <= fire_i[2] ? (bad_dst_i ? ~station_i : station_i)
                               : ~pattern_dst_o;
  end
endmodule : pwig_evt_src

// file: dv/pwig_port_properties.sv
// Purpose: Port-level properties of the wake and interrupt block.
// Assumes: PORT_NUM is 1 and the port has a transceiver.
// Notes:   Bound from the testbench top.
`timescale 1ns/10ps
module pwig_props (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] addr_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic [47:0] station_addr_i,
  input wire logic        pattern_det_i,
  input wire logic [47:0] pattern_dst_i,
  input wire logic        link_up_i,
  input wire logic        energy_i,
  input wire logic        phy_irq_i,
  input wire logic        filter_irq_i,
  input wire logic        wake_event_out_o,
  input wire logic        port_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire st_rd = rd_en_i && addr_i == 16'h101B;
  wire pat = pattern_det_i && pattern_dst_i == station_addr_i;
  property p_rd_idle; !$past(rd_en_i) |-> rd_data_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_resv; $past(rd_en_i) |-> rd_data_o[7:3] == 5'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_phy; $past(st_rd) |-> rd_data_o[1] == $past(phy_irq_i);
  endproperty
  a_phy: assert property (p_phy) else $error("phy status wrong");
  property p_acl; filter_irq_i ##1 !wr_en_i ##1 st_rd |=> rd_data_o[0];
  endproperty
  a_acl: assert property (p_acl) else $error("filter status lost");
  property p_wk_up; $rose(wake_event_out_o) |->
    $past(energy_i || link_up_i || pat || wr_en_i); endproperty
  a_wk_up: assert property (p_wk_up) else $error("wake no cause");
  property p_wk_dn; $fell(wake_event_out_o) |-> $past(wr_en_i); endproperty
  a_wk_dn: assert property (p_wk_dn) else $error("wake dropped");
  property p_irq_up; $rose(port_irq_o) |->
    $past(filter_irq_i || phy_irq_i || wr_en_i); endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq no cause");
  property p_irq_dn; $fell(port_irq_o) |-> $past(wr_en_i || !phy_irq_i);
  endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq dropped");
  property p_rst; $fell(reset_i) |-> !port_irq_o && !wake_event_out_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule : pwig_props

// file: dv/tb_port_wake_and_interrupt_gating.sv
// Purpose: Self-checking bench for the port wake and interrupt block.
// Assumes: Port 1 with a transceiver.
// Notes:   Events come from the detector model one cycle after fire.
`timescale 1ns/10ps
module tb_port_wake_and_interrupt_gating;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_en_i = 1'b0;
  logic        rd_en_i = 1'b0;
  logic        phy_irq_i = 1'b0;
  logic        bad_dst = 1'b0;
  logic [3:0]  fire = 4'h0;
  logic [47:0] station_addr_i = 48'hA5C3_0F1E_7D42;
  logic [47:0] pattern_dst_i;
  logic [7:0]  rd_data_o;
  logic        pattern_det_i, link_up_i, energy_i, filter_irq_i;
  logic        wake_event_out_o, port_irq_o, wake_irq_o;
  int          n_mismatch = 0;
  int          checked = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  pwig_port_wake_irq dut (.core_clk_i, .reset_i, .addr_i, .wr_data_i,
    .wr_en_i, .rd_en_i, .rd_data_o, .station_addr_i, .pattern_det_i,
    .pattern_dst_i, .link_up_i, .energy_i, .phy_irq_i, .filter_irq_i,
    .wake_event_out_o, .port_irq_o, .wake_irq_o);
  pwig_evt_src u_src (.core_clk_i, .fire_i(fire), .bad_dst_i(bad_dst),
    .station_i(station_addr_i), .energy_o(energy_i), .link_up_o(link_up_i),
    .pattern_det_o(pattern_det_i), .filter_irq_o(filter_irq_i),
    .pattern_dst_o(pattern_dst_i));
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rd_data_o);
  endtask : rd
  task automatic ev(input logic [3:0] f);
    @(posedge core_clk_i);
    fire <= f;
    @(posedge core_clk_i);
    fire <= 4'h0;
    @(posedge core_clk_i);
    #1;
  endtask : ev
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(16'h1017, 8'h00);
    rd(16'h101F, 8'h00);
    for (int b = 0; b < 3; b++) begin
      wr(16'h1017, 8'h01 << b);
      ev(4'h1 << b);
      chk("wake on", 8'h01, {7'h0, wake_event_out_o});
      rd(16'h1013, 8'h01 << b);
      wr(16'h1013, 8'h01 << b);
      chk("wake clr", 8'h00, {7'h0, wake_event_out_o});
      wr(16'h1017, 8'h00);
      ev(4'h1 << b);
      chk("wake off", 8'h00, {7'h0, wake_event_out_o});
      wr(16'h1013, 8'h07);
    end
    wr(16'h1017, 8'h04);
    @(posedge core_clk_i);
    bad_dst <= 1'b1;
    ev(4'h4);
    chk("wake dst", 8'h00, {7'h0, wake_event_out_o});
    $display("wake test done");
    ev(4'h8);
    chk("irq acl", 8'h01, {7'h0, port_irq_o});
    rd(16'h101B, 8'h01);
    rd(16'h101B, 8'h01);
    wr(16'h101F, 8'h01);
    chk("irq tog", 8'h00, {7'h0, port_irq_o});
    rd(16'h101B, 8'h00);
    ev(4'h8);
    chk("irq mask", 8'h00, {7'h0, port_irq_o});
    wr(16'h101F, 8'h00);
    rd(16'h101B, 8'h00);
    @(posedge core_clk_i);
    phy_irq_i <= 1'b1;
    rd(16'h101B, 8'h02);
    chk("irq phy", 8'h01, {7'h0, port_irq_o});
    wr(16'h101F, 8'h02);
    chk("irq pmsk", 8'h00, {7'h0, port_irq_o});
    @(posedge core_clk_i);
    phy_irq_i <= 1'b0;
    $display("port irq test done");
    rd(16'h100C, 8'h07);
    wr(16'h1017, 8'h01);
    wr(16'h100D, 8'h01);
    ev(4'h1);
    chk("wirq", 8'h01, {7'h0, wake_irq_o});
    rd(16'h100C, 8'h01);
    chk("wirq clr", 8'h00, {7'h0, wake_irq_o});
    wr(16'h100D, 8'h00);
    ev(4'h1);
    chk("wirq msk", 8'h00, {7'h0, wake_irq_o});
    rd(16'h1050, 8'h00);
    wr(16'h201F, 8'h01);
    rd(16'h101F, 8'h02);
    $display("bus test done");
    final_report();
  end
endmodule : tb_port_wake_and_interrupt_gating
bind pwig_port_wake_irq pwig_props u_props (.core_clk_i, .reset_i, .addr_i,
  .wr_en_i, .rd_en_i, .rd_data_o, .station_addr_i, .pattern_det_i,
  .pattern_dst_i, .link_up_i, .energy_i, .phy_irq_i, .filter_irq_i,
  .wake_event_out_o, .port_irq_o);
